// *** shared/scgc_params.svh ***
`ifndef SCGC_PARAMS_SVH
`define SCGC_PARAMS_SVH

// ----------------------------------------------------------------
// Register window
// ----------------------------------------------------------------
`define SCGC_BASE         24'hFFFC00
`define SCGC_WIN_LSB      6
`define SCGC_OFS_CFG      6'h00
`define SCGC_OFS_TEST     6'h02
`define SCGC_OFS_ULVL     6'h04
`define SCGC_OFS_SLVL     6'h06
`define SCGC_OFS_PINS     6'h08
`define SCGC_OFS_PORT     6'h0A
`define SCGC_OFS_PINRD    6'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCGC_STOP_BIT     15
`define SCGC_SUPERVISOR_ACCESS_BIT_BIT     7
`define SCGC_ARBITRATION_NUMBER_FIELD_MSB     3
`define SCGC_ARBITRATION_NUMBER_FIELD_LSB     0
`define SCGC_HLVL_MSB     10
`define SCGC_HLVL_LSB     8
`define SCGC_LLVL_MSB     2
`define SCGC_LLVL_LSB     0
`define SCGC_VEC_MSB      7
`define SCGC_VEC_LSB      2
`define SCGC_PA_MSB       10
`define SCGC_PA_LSB       8
`define SCGC_BYTE_MSB     7

// ----------------------------------------------------------------
// Reset values and vector codes
// ----------------------------------------------------------------
`define SCGC_STOP_RST     1'h0
`define SCGC_SUPERVISOR_ACCESS_BIT_RST     1'h1
`define SCGC_ARBITRATION_NUMBER_FIELD_RST     4'h0
`define SCGC_LVL_RST      3'h0
`define SCGC_VEC_RST      6'h03
`define SCGC_PA_RST       3'h0
`define SCGC_BYTE_RST     8'h00
`define SCGC_CODE_UA      2'h0
`define SCGC_CODE_UB      2'h1
`define SCGC_CODE_SS      2'h2

`endif

// *** shared/scgc_pkg.sv ***
`default_nettype none

package scgc_pkg;

  // Intermodule bus request, one cycle strobe
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } scgc_bus_req_s;

  // Interrupt acknowledge from the processor
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } scgc_iack_s;

  // Pin configuration handed to the serial channels
  typedef struct packed {
    logic [2:0] assign_sel;
    logic [7:0] direction;
    logic [7:0] data;
  } scgc_pin_cfg_s;

  typedef enum logic [2:0] {
    SCGC_IDLE = 3'h1,
    SCGC_ARB  = 3'h2,
    SCGC_VEC  = 3'h4
  } scgc_arb_e;

endpackage

`default_nettype wire

// *** design/scgc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scgc_params.svh"

// Contract
// - Decode 64-byte register window on bus
// - Unimplemented bits ignore writes, read zero
// - Stop bit gates module clock off
// - Stop holds until write or reset
// - Supervisor bit stored, no access effect
// - Per-channel level 0 disabled to 7
// - UART A and B levels separate, serial level separate
// - Equal level: serial, UART A, UART B
// - Join arbitration only on level match
// - Highest presented arbitration number wins
// - Arbitration number zero means no arbitration
// - Vector: six base bits plus channel code
// - Three adjacent vectors from one base
// - Pin register selects serial or GPIO
// - Module map bit clear: no response
module scgc_top
  import scgc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Register bus
  input  wire scgc_bus_req_s bus_in,
  input  wire logic          module_map_bit,
  output logic               bus_ack,
  output logic [15:0]        bus_rdata,
  // Channel requests and acknowledge
  input  wire logic          irq_sync_serial,
  input  wire logic          irq_uart_a,
  input  wire logic          irq_uart_b,
  input  wire scgc_iack_s    iack,
  input  wire logic [3:0]    arb_in,
  output logic [2:0]         irq_req_level,
  output logic [3:0]         arb_out,
  output logic               arb_oe,
  output logic [7:0]         vector_out,
  output logic               vector_oe,
  // Module control
  output logic               module_clk_en,
  input  wire logic [7:0]    pin_in,
  output scgc_pin_cfg_s      pin_cfg
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta <= `SCGC_BYTE_RST;
      pin_sync <= `SCGC_BYTE_RST;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       stop;
  logic       supervisor_access_bit;
  logic [3:0] arbitration_number_field;
  logic [2:0] lvl_a;
  logic [2:0] lvl_b;
  logic [2:0] lvl_s;
  logic [5:0] vec_base;
  logic [2:0] pin_assign;
  logic [7:0] pin_dir;
  logic [7:0] port_data;
  logic       next_stop;
  logic       next_supervisor_access_bit;
  logic [3:0] next_arbitration_number_field;
  logic [2:0] next_lvl_a;
  logic [2:0] next_lvl_b;
  logic [2:0] next_lvl_s;
  logic [5:0] next_vec_base;
  logic [2:0] next_pin_assign;
  logic [7:0] next_pin_dir;
  logic [7:0] next_port_data;
  logic       hit;
  logic [5:0] ofs;

  // Window hit also needs the module map bit
  // window decode
  assign hit = bus_in.req && module_map_bit &&
               (bus_in.addr[23:`SCGC_WIN_LSB] ==
                18'(`SCGC_BASE >> `SCGC_WIN_LSB));
  // Word access only; the odd byte address selects the same word
  assign ofs = {bus_in.addr[5:1], 1'b0};

  always_comb begin
    next_stop       = stop;
    next_supervisor_access_bit       = supervisor_access_bit;
    next_arbitration_number_field       = arbitration_number_field;
    next_lvl_a      = lvl_a;
    next_lvl_b      = lvl_b;
    next_lvl_s      = lvl_s;
    next_vec_base   = vec_base;
    next_pin_assign = pin_assign;
    next_pin_dir    = pin_dir;
    next_port_data  = port_data;
    // Bus stays live while stopped so software can clear stop
    // stop held
    if (hit && bus_in.wr) begin
      unique case (ofs)
        `SCGC_OFS_CFG: begin
          next_stop = bus_in.wdata[`SCGC_STOP_BIT];
          next_supervisor_access_bit = bus_in.wdata[`SCGC_SUPERVISOR_ACCESS_BIT_BIT];
          next_arbitration_number_field = bus_in.wdata[`SCGC_ARBITRATION_NUMBER_FIELD_MSB:`SCGC_ARBITRATION_NUMBER_FIELD_LSB];
        end
        `SCGC_OFS_ULVL: begin
          next_lvl_a = bus_in.wdata[`SCGC_HLVL_MSB:`SCGC_HLVL_LSB];
          next_lvl_b = bus_in.wdata[`SCGC_LLVL_MSB:`SCGC_LLVL_LSB];
        end
        `SCGC_OFS_SLVL: begin
          next_lvl_s    = bus_in.wdata[`SCGC_HLVL_MSB:`SCGC_HLVL_LSB];
          next_vec_base = bus_in.wdata[`SCGC_VEC_MSB:`SCGC_VEC_LSB];
        end
        `SCGC_OFS_PINS: begin
          next_pin_assign = bus_in.wdata[`SCGC_PA_MSB:`SCGC_PA_LSB];
          next_pin_dir    = bus_in.wdata[`SCGC_BYTE_MSB:0];
        end
        `SCGC_OFS_PORT: next_port_data = bus_in.wdata[`SCGC_BYTE_MSB:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stop       <= `SCGC_STOP_RST;
      supervisor_access_bit       <= `SCGC_SUPERVISOR_ACCESS_BIT_RST;
      arbitration_number_field       <= `SCGC_ARBITRATION_NUMBER_FIELD_RST;
      lvl_a      <= `SCGC_LVL_RST;
      lvl_b      <= `SCGC_LVL_RST;
      lvl_s      <= `SCGC_LVL_RST;
      vec_base   <= `SCGC_VEC_RST;
      pin_assign <= `SCGC_PA_RST;
      pin_dir    <= `SCGC_BYTE_RST;
      port_data  <= `SCGC_BYTE_RST;
    end else begin
      stop       <= next_stop;
      supervisor_access_bit       <= next_supervisor_access_bit;
      arbitration_number_field       <= next_arbitration_number_field;
      lvl_a      <= next_lvl_a;
      lvl_b      <= next_lvl_b;
      lvl_s      <= next_lvl_s;
      vec_base   <= next_vec_base;
      pin_assign <= next_pin_assign;
      pin_dir    <= next_pin_dir;
      port_data  <= next_port_data;
    end
  end

  assign module_clk_en          = ~stop;
  // One driver for the whole struct keeps the variable single-sourced
  assign pin_cfg = '{assign_sel: pin_assign,
                     direction:  pin_dir,
                     data:       port_data};

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  logic        next_ack;

  always_comb begin
    next_ack   = hit;
    next_rdata = 16'h0000;
    if (hit && !bus_in.wr) begin
      unique case (ofs)
        `SCGC_OFS_CFG: begin
          next_rdata[`SCGC_STOP_BIT] = stop;
          next_rdata[`SCGC_SUPERVISOR_ACCESS_BIT_BIT] = supervisor_access_bit;
          next_rdata[`SCGC_ARBITRATION_NUMBER_FIELD_MSB:`SCGC_ARBITRATION_NUMBER_FIELD_LSB] = arbitration_number_field;
        end
        `SCGC_OFS_ULVL: begin
          next_rdata[`SCGC_HLVL_MSB:`SCGC_HLVL_LSB] = lvl_a;
          next_rdata[`SCGC_LLVL_MSB:`SCGC_LLVL_LSB] = lvl_b;
        end
        `SCGC_OFS_SLVL: begin
          next_rdata[`SCGC_HLVL_MSB:`SCGC_HLVL_LSB] = lvl_s;
          next_rdata[`SCGC_VEC_MSB:`SCGC_VEC_LSB]   = vec_base;
        end
        `SCGC_OFS_PINS: begin
          next_rdata[`SCGC_PA_MSB:`SCGC_PA_LSB] = pin_assign;
          next_rdata[`SCGC_BYTE_MSB:0]          = pin_dir;
        end
        `SCGC_OFS_PORT:  next_rdata[`SCGC_BYTE_MSB:0] = port_data;
        `SCGC_OFS_PINRD: next_rdata[`SCGC_BYTE_MSB:0] = pin_sync;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_ack   <= 1'b0;
      bus_rdata <= 16'h0000;
    end else begin
      bus_ack   <= next_ack;
      bus_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and acknowledge arbitration
  // ----------------------------------------------------------------
  scgc_arb_e  state;
  scgc_arb_e  next_state;
  logic [1:0] chan;
  logic [1:0] next_chan;
  logic [2:0] next_req_level;
  logic [7:0] next_vector;
  logic       act_s;
  logic       act_a;
  logic       act_b;

  assign act_s = irq_sync_serial && (lvl_s != `SCGC_LVL_RST);
  assign act_a = irq_uart_a && (lvl_a != `SCGC_LVL_RST);
  assign act_b = irq_uart_b && (lvl_b != `SCGC_LVL_RST);

  always_comb begin
    next_state     = state;
    next_chan      = chan;
    next_vector    = vector_out;
    next_req_level = `SCGC_LVL_RST;
    if (act_b) next_req_level = lvl_b;
    if (act_a && lvl_a > next_req_level) next_req_level = lvl_a;
    if (act_s && lvl_s > next_req_level) next_req_level = lvl_s;
    unique case (state)
      SCGC_IDLE: begin
        if (iack.valid && arbitration_number_field != `SCGC_ARBITRATION_NUMBER_FIELD_RST) begin
          if (act_s && lvl_s == iack.level) begin
            next_chan  = `SCGC_CODE_SS;
            next_state = SCGC_ARB;
          end else if (act_a && lvl_a == iack.level) begin
            next_chan  = `SCGC_CODE_UA;
            next_state = SCGC_ARB;
          end else if (act_b && lvl_b == iack.level) begin
            next_chan  = `SCGC_CODE_UB;
            next_state = SCGC_ARB;
          end
        end
      end
      SCGC_ARB: begin
        if (arb_in == arbitration_number_field) begin
          next_vector = {vec_base, chan};
          next_state  = SCGC_VEC;
        end else begin
          next_state = SCGC_IDLE;
        end
      end
      SCGC_VEC: next_state = SCGC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state         <= SCGC_IDLE;
      chan          <= `SCGC_CODE_UA;
      vector_out    <= `SCGC_BYTE_RST;
      irq_req_level <= `SCGC_LVL_RST;
    end else begin
      state         <= next_state;
      chan          <= next_chan;
      vector_out    <= next_vector;
      irq_req_level <= next_req_level;
    end
  end

  // drive only when competing or won
  assign arb_oe    = (state == SCGC_ARB);
  assign arb_out   = arbitration_number_field;
  assign vector_oe = (state == SCGC_VEC);

endmodule // scgc_top

`default_nettype wire

// *** verification/scgc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// Port checker
// ----------------------------------------------------------
module scgc_properties
  import scgc_pkg::*;
(
  // Clock, reset and bus
  input wire logic          clk,
  input wire logic          reset,
  input wire scgc_bus_req_s bus_in,
  input wire logic          module_map_bit,
  input wire logic          bus_ack,
  input wire logic [15:0]   bus_rdata,
  // Requests and acknowledge
  input wire logic          irq_sync_serial,
  input wire logic          irq_uart_a,
  input wire logic          irq_uart_b,
  input wire scgc_iack_s    iack,
  input wire logic [3:0]    arb_in,
  input wire logic [2:0]    irq_req_level,
  input wire logic [3:0]    arb_out,
  input wire logic          arb_oe,
  input wire logic [7:0]    vector_out,
  input wire logic          vector_oe,
  // Module control
  input wire logic          module_clk_en,
  input wire logic [7:0]    pin_in,
  input wire scgc_pin_cfg_s pin_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic hit;
  logic cfg_wr;
  assign hit = bus_in.req && module_map_bit && bus_in.addr[23:6] == 18'h3FFF0;
  assign cfg_wr = hit && bus_in.wr && bus_in.addr[5:1] == 5'h00;
  property p_ack; hit |=> bus_ack; endproperty
  a_ack: assert property (p_ack) else $error("No ack on hit");
  property p_refuse; !hit |=> !bus_ack; endproperty
  a_refuse: assert property (p_refuse) else $error("Ack w/o hit");
  property p_stop;
    bus_ack && $past(cfg_wr) |-> module_clk_en == !$past(bus_in.wdata[15]);
  endproperty
  a_stop: assert property (p_stop) else $error("Stop not applied");
  property p_hold; $changed(module_clk_en) |-> $past(cfg_wr); endproperty
  a_hold: assert property (p_hold) else $error("Stop moved alone");
  property p_join; arb_oe |-> $past(iack.valid) ##1 !arb_oe; endproperty
  a_join: assert property (p_join) else $error("Arb w/o iack");
  property p_nonzero; arb_oe |-> arb_out != 4'h0; endproperty
  a_nonzero: assert property (p_nonzero)
    else $error("Arb with zero");
  property p_win;
    vector_oe |-> $past(arb_oe) && $past(arb_in) == $past(arb_out);
  endproperty
  a_win: assert property (p_win) else $error("Vector w/o win");
  property p_lost; arb_oe && arb_in != arb_out |=> !vector_oe; endproperty
  a_lost: assert property (p_lost)
    else $error("Vector after loss");
  property p_code; vector_oe |-> vector_out[1:0] != 2'h3; endproperty
  a_code: assert property (p_code)
    else $error("Bad channel code");
  property p_quiet;
    !(irq_sync_serial || irq_uart_a || irq_uart_b) [*2]
      |-> irq_req_level == 3'h0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Level w/o request");
endmodule // scgc_properties

bind scgc_top scgc_properties i_props (.clk, .reset, .bus_in,
  .module_map_bit, .bus_ack, .bus_rdata, .irq_sync_serial, .irq_uart_a,
  .irq_uart_b, .iack, .arb_in, .irq_req_level, .arb_out, .arb_oe,
  .vector_out, .vector_oe, .module_clk_en, .pin_in, .pin_cfg);
`default_nettype wire

// *** verification/scgc_arb_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// Arbitration lines as the bus resolves them
// ----------------------------------------------------------
module scgc_arb_peer (
  // Drivers
  input  wire logic       arb_oe,
  input  wire logic [3:0] arb_out,
  input  wire logic [3:0] rival,
  // Resolved number
  output logic [3:0]      arb_in
);
  always_comb begin
    arb_in = rival;
    if (arb_oe && arb_out > rival) begin
      arb_in = arb_out;
    end
  end
endmodule // scgc_arb_peer
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scgc_params.svh"
module tb_top
  import scgc_pkg::*;
  ();
  logic clk = 1'b0;
  logic reset = 1'b1;
  scgc_bus_req_s bus_in = '0;
  logic module_map_bit = 1'b1;
  logic [2:0] irq = 3'h0;
  scgc_iack_s iack = '0;
  logic [3:0] rival = 4'h0;
  logic [7:0] pin_in = 8'h5A;
  logic bus_ack, arb_oe, vector_oe, module_clk_en, ack;
  logic [15:0] bus_rdata, rd;
  logic [3:0] arb_in, arb_out;
  logic [2:0] irq_req_level;
  logic [7:0] vector_out;
  scgc_pin_cfg_s pin_cfg;
  int errors = 0;
  int n_compared = 0;
  localparam logic [23:0] B = `SCGC_BASE;
  // Offset, written value, value read back
  logic [37:0] rows [9] = '{{6'h00, 16'h7F85, 16'h0085},
    {6'h02, 16'hFFFF, 16'h0000}, {6'h04, 16'hFFFF, 16'h0707},
    {6'h06, 16'hFFFF, 16'h07FC}, {6'h08, 16'hFFFF, 16'h07FF},
    {6'h0A, 16'hFFFF, 16'h00FF}, {6'h0C, 16'hFFFF, 16'h005A},
    {6'h10, 16'hFFFF, 16'h0000}, {6'h3E, 16'hFFFF, 16'h0000}};
  always #12.5 clk = ~clk;
  scgc_top i_dut (.clk, .reset, .bus_in, .module_map_bit, .bus_ack,
    .bus_rdata, .irq_sync_serial(irq[2]), .irq_uart_a(irq[1]),
    .irq_uart_b(irq[0]), .iack, .arb_in, .irq_req_level, .arb_out,
    .arb_oe, .vector_out, .vector_oe, .module_clk_en, .pin_in, .pin_cfg);
  scgc_arb_peer i_peer (.arb_oe, .arb_out, .rival, .arb_in);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [23:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    #1 bus_in = '{1'b1, wr, a, d};
    @(posedge clk);
    #1 bus_in.req = 1'b0;
    ack = bus_ack;
    rd = bus_rdata;
  endtask
  task automatic ack_run(input logic [2:0] lvl, input logic e_arb,
                         input logic e_vec, input logic [7:0] e_v);
    @(posedge clk);
    #1 iack = '{1'b1, lvl};
    @(posedge clk);
    #1 iack.valid = 1'b0;
    chk({15'h0, arb_oe}, {15'h0, e_arb});
    @(posedge clk);
    #1 chk({15'h0, vector_oe}, {15'h0, e_vec});
    if (e_vec) chk({8'h0, vector_out}, {8'h0, e_v});
  endtask
  task automatic summarize();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Long enough for every test with a wide margin
  initial begin
    #(25 * 4000);
    errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, B | {18'h0, rows[i][37:32]}, rows[i][31:16]);
      chk({15'h0, ack}, 16'h0001);
      bus(1'b0, B | {18'h0, rows[i][37:32]}, 16'h0000);
      chk(rd, rows[i][15:0]);
    end
    chk({5'h0, pin_cfg.assign_sel, pin_cfg.direction}, 16'h07FF);
    chk({8'h0, pin_cfg.data}, 16'h00FF);
    module_map_bit = 1'b0;
    bus(1'b1, B, 16'h8005);
    chk({15'h0, ack}, 16'h0000);
    module_map_bit = 1'b1;
    bus(1'b1, B + 24'h40, 16'h8005);
    chk({15'h0, ack}, 16'h0000);
    bus(1'b0, B, 16'h0000);
    chk(rd, 16'h0085);
    bus(1'b1, B, 16'h8085);
    chk({15'h0, module_clk_en}, 16'h0000);
    bus(1'b0, B, 16'h0000);
    chk(rd, 16'h8085);
    bus(1'b1, B, 16'h0085);
    chk({15'h0, module_clk_en}, 16'h0001);
    bus(1'b1, B | 24'h4, 16'h0303);
    bus(1'b1, B | 24'h6, 16'h0340);
    irq = 3'h7;
    repeat (2) @(posedge clk);
    #1 chk({13'h0, irq_req_level}, 16'h0003);
    ack_run(3'h3, 1'b1, 1'b1, 8'h42);
    irq = 3'h3;
    ack_run(3'h3, 1'b1, 1'b1, 8'h40);
    irq = 3'h1;
    ack_run(3'h3, 1'b1, 1'b1, 8'h41);
    ack_run(3'h4, 1'b0, 1'b0, 8'h00);
    rival = 4'h7;
    ack_run(3'h3, 1'b1, 1'b0, 8'h00);
    rival = 4'h0;
    bus(1'b1, B, 16'h0080);
    ack_run(3'h3, 1'b0, 1'b0, 8'h00);
    irq = 3'h0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    bus(1'b0, B, 16'h0000);
    chk(rd, 16'h0080);
    bus(1'b0, B | 24'h6, 16'h0000);
    chk(rd, 16'h000C);
    // Supervisor bit cleared must store and leave access working
    bus(1'b1, B, 16'h0005);
    bus(1'b0, B, 16'h0000);
    chk(rd, 16'h0005);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
